// [common/eesfe_pkg.sv]
/*
 * eesfe_pkg: constants and carrier types of the serial EEPROM front end.
 * Assumes a single system clock that samples every serial pin.
 */
package eesfe_pkg;

    // array geometry: large and small density variants
    localparam int EESFE_ADDR_W = 11;
    localparam int EESFE_DEPTH_LARGE = 2048;
    localparam int EESFE_DEPTH_SMALL = 1024;
    localparam logic [EESFE_ADDR_W-1:0] EESFE_MASK_LARGE = 11'h7FF;
    localparam logic [EESFE_ADDR_W-1:0] EESFE_MASK_SMALL = 11'h3FF;
    localparam logic [EESFE_ADDR_W-1:0] EESFE_ADDR_ONE = 11'h001;
    localparam int EESFE_AHI_W = EESFE_ADDR_W - 8;

    // bit counter
    localparam logic [2:0] EESFE_BIT_FIRST = 3'h0;
    localparam logic [2:0] EESFE_BIT_LAST = 3'h7;
    localparam logic [2:0] EESFE_BIT_ONE = 3'h1;

    // opcodes
    localparam logic [7:0] EESFE_OP_WREN = 8'h06;
    localparam logic [7:0] EESFE_OP_WRDI = 8'h04;
    localparam logic [7:0] EESFE_OP_RDSR = 8'h05;
    localparam logic [7:0] EESFE_OP_WRSR = 8'h01;
    localparam logic [7:0] EESFE_OP_READ = 8'h03;
    localparam logic [7:0] EESFE_OP_WRITE = 8'h02;

    // status byte field positions
    localparam int EESFE_SR_WIP = 0;
    localparam int EESFE_SR_WEL = 1;
    localparam int EESFE_SR_BP_LO = 2;
    localparam int EESFE_SR_BP_HI = 3;
    localparam int EESFE_SR_SRWD = 7;

    // block protect encodings
    localparam logic [1:0] EESFE_BP_NONE = 2'h0;
    localparam logic [1:0] EESFE_BP_QUARTER = 2'h1;
    localparam logic [1:0] EESFE_BP_HALF = 2'h2;
    localparam logic [1:0] EESFE_BP_ALL = 2'h3;

    // pin vector order: sck, mosi, cs_n, hold_n, wp_n (msb first)
    localparam int EESFE_NPINS = 5;
    localparam logic [EESFE_NPINS-1:0] EESFE_PIN_IDLE = 5'h07;
    // synchroniser reset view: select reads low, so a select pin held low
    // through reset is never taken for a fresh falling edge
    localparam logic [EESFE_NPINS-1:0] EESFE_PIN_RST = 5'h03;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic cs_n;
        logic hold_n;
        logic wp_n;
    } eesfe_pins_t;

    typedef struct packed {
        logic miso;
        logic miso_oe;
    } eesfe_link_t;

    typedef struct packed {
        logic active;
        logic standby;
        logic held;
        logic armed;
    } eesfe_state_t;

    typedef enum logic [2:0] {
        ST_OPCODE,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_RD_DATA,
        ST_WR_DATA,
        ST_SR_DATA,
        ST_RDSR,
        ST_IGNORE
    } eesfe_phase_t;

endpackage : eesfe_pkg

// [design/eesfe_front.sv]
/*
 * eesfe_front: serial front end of a byte-wide SPI EEPROM (modes 0 and 3).
 * Assumes i_clk runs well above the serial clock; all pins are async.
 */
`timescale 1ns/1ps
`default_nettype none
module eesfe_front #(
    parameter logic P_LARGE = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire eesfe_pkg::eesfe_pins_t i_pins,
    output var eesfe_pkg::eesfe_link_t o_link,
    output var eesfe_pkg::eesfe_state_t o_state
);
    import eesfe_pkg::*;

    localparam logic [EESFE_ADDR_W-1:0] AMASK =
        P_LARGE ? EESFE_MASK_LARGE : EESFE_MASK_SMALL;

    logic [EESFE_NPINS-1:0] pins_raw;
    logic [EESFE_NPINS-1:0] pins_sync;
    eesfe_pins_t ps;

    assign pins_raw = i_pins;

    // every pin is asynchronous to i_clk, mode-independent sampling
    for (genvar g = 0; g < EESFE_NPINS; g++)
    begin : g_sync
        eesfe_sync2 #(.INIT(EESFE_PIN_RST[g])) u_sync (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_d(pins_raw[g]),
            .o_q(pins_sync[g])
        );
    end
    assign ps = pins_sync;

    logic sck_d_r;
    logic cs_d_r;
    logic armed_r, armed_nxt;
    logic hold_r, hold_nxt;
    logic talk_r, talk_nxt;
    logic rd_r, rd_nxt;
    logic wel_r, wel_nxt;
    logic pend_r, pend_nxt;
    logic srwd_r, srwd_nxt;
    logic [1:0] bp_r, bp_nxt;
    logic miso_r, miso_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [2:0] ocnt_r, ocnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] osh_r, osh_nxt;
    logic [EESFE_ADDR_W-1:0] addr_r, addr_nxt;
    eesfe_phase_t st_r, st_nxt;
    logic [7:0] mem_r [EESFE_DEPTH_LARGE];
    logic mem_we;
    logic [EESFE_ADDR_W-1:0] mem_wa;
    logic [7:0] mem_wd;

    logic sel, rise, fall, cs_fall, out_phase, frozen;
    logic [7:0] byte_in, status, next_byte;

    function automatic logic prot_f(input logic [EESFE_ADDR_W-1:0] a,
                                    input logic [1:0] bp);
        logic [1:0] top;
        top = P_LARGE ? a[EESFE_ADDR_W-1 -: 2] : a[EESFE_ADDR_W-2 -: 2];
        unique case (bp)
            EESFE_BP_NONE: prot_f = 1'b0;
            EESFE_BP_QUARTER: prot_f = &top;
            EESFE_BP_HALF: prot_f = top[1];
            EESFE_BP_ALL: prot_f = 1'b1;
        endcase
    endfunction : prot_f

    assign cs_fall = cs_d_r & ~ps.cs_n;
    assign sel = armed_r & ~ps.cs_n;
    // edges are dropped while held
    assign rise = sel & ~hold_r & ps.sck & ~sck_d_r;
    assign fall = sel & ~hold_r & ~ps.sck & sck_d_r;
    assign byte_in = {sh_r[6:0], ps.mosi};
    assign out_phase = (st_r == ST_RD_DATA) || (st_r == ST_RDSR);
    assign frozen = srwd_r & ~ps.wp_n;
    always_comb
    begin
        status = 8'h00;
        status[EESFE_SR_SRWD] = srwd_r;
        status[EESFE_SR_BP_HI] = bp_r[1];
        status[EESFE_SR_BP_LO] = bp_r[0];
        status[EESFE_SR_WEL] = wel_r;
        status[EESFE_SR_WIP] = 1'b0;
    end
    assign next_byte = (st_r == ST_RD_DATA) ? mem_r[addr_r] : status;

    always_comb
    begin
        armed_nxt = armed_r;
        hold_nxt = hold_r;
        talk_nxt = talk_r;
        rd_nxt = rd_r;
        wel_nxt = wel_r;
        pend_nxt = pend_r;
        srwd_nxt = srwd_r;
        bp_nxt = bp_r;
        miso_nxt = miso_r;
        bit_nxt = bit_r;
        ocnt_nxt = ocnt_r;
        sh_nxt = sh_r;
        osh_nxt = osh_r;
        addr_nxt = addr_r;
        st_nxt = st_r;
        mem_we = 1'b0;
        mem_wa = addr_r;
        mem_wd = byte_in;
        if (cs_fall)
            armed_nxt = 1'b1;
        if (!sel)
        begin
            // deselect drops hold and any half-done sequence
            st_nxt = ST_OPCODE;
            bit_nxt = EESFE_BIT_FIRST;
            hold_nxt = 1'b0;
            talk_nxt = 1'b0;
            ocnt_nxt = EESFE_BIT_FIRST;
            if (pend_r)
            begin
                wel_nxt = 1'b0;
                pend_nxt = 1'b0;
            end
        end
        else
        begin
            if (!hold_r && !ps.hold_n && !ps.sck)
                hold_nxt = 1'b1;
            else if (hold_r && ps.hold_n && !ps.sck)
                hold_nxt = 1'b0;
            if (rise)
            begin
                sh_nxt = byte_in;
                bit_nxt = bit_r + EESFE_BIT_ONE;
                if (bit_r == EESFE_BIT_LAST)
                begin
                    unique case (st_r)
                        ST_OPCODE:
                        begin
                            unique case (byte_in)
                                EESFE_OP_WREN:
                                begin
                                    wel_nxt = 1'b1;
                                    st_nxt = ST_IGNORE;
                                end
                                EESFE_OP_WRDI:
                                begin
                                    wel_nxt = 1'b0;
                                    st_nxt = ST_IGNORE;
                                end
                                EESFE_OP_RDSR: st_nxt = ST_RDSR;
                                EESFE_OP_WRSR: st_nxt = ST_SR_DATA;
                                EESFE_OP_READ:
                                begin
                                    rd_nxt = 1'b1;
                                    st_nxt = ST_ADDR_HI;
                                end
                                EESFE_OP_WRITE:
                                begin
                                    rd_nxt = 1'b0;
                                    st_nxt = ST_ADDR_HI;
                                end
                                default: st_nxt = ST_IGNORE;
                            endcase
                        end
                        ST_ADDR_HI:
                        begin
                            addr_nxt = {byte_in[EESFE_AHI_W-1:0],
                                        addr_r[7:0]} & AMASK;
                            st_nxt = ST_ADDR_LO;
                        end
                        ST_ADDR_LO:
                        begin
                            addr_nxt = {addr_r[EESFE_ADDR_W-1:8],
                                        byte_in} & AMASK;
                            st_nxt = rd_r ? ST_RD_DATA : ST_WR_DATA;
                        end
                        ST_WR_DATA:
                        begin
                            // protected bytes are silently dropped
                            mem_we = wel_r & ~prot_f(addr_r, bp_r);
                            pend_nxt = 1'b1;
                            addr_nxt = (addr_r + EESFE_ADDR_ONE) & AMASK;
                        end
                        ST_SR_DATA:
                        begin
                            if (wel_r && !frozen)
                            begin
                                srwd_nxt = byte_in[EESFE_SR_SRWD];
                                bp_nxt = {byte_in[EESFE_SR_BP_HI],
                                          byte_in[EESFE_SR_BP_LO]};
                            end
                            wel_nxt = 1'b0;
                            st_nxt = ST_IGNORE;
                        end
                        ST_RD_DATA, ST_RDSR, ST_IGNORE: ;
                    endcase
                end
            end
            if (fall && out_phase)
            begin
                talk_nxt = 1'b1;
                ocnt_nxt = ocnt_r + EESFE_BIT_ONE;
                if (ocnt_r == EESFE_BIT_FIRST)
                begin
                    // fetch at byte start keeps sequential reads rolling
                    miso_nxt = next_byte[7];
                    osh_nxt = {next_byte[6:0], 1'b0};
                    if (st_r == ST_RD_DATA)
                        addr_nxt = (addr_r + EESFE_ADDR_ONE) & AMASK;
                end
                else
                begin
                    miso_nxt = osh_r[7];
                    osh_nxt = {osh_r[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            sck_d_r <= 1'b0;
            // low, so only a seen high-then-low select arms
            cs_d_r <= 1'b0;
            armed_r <= 1'b0;
            hold_r <= 1'b0;
            talk_r <= 1'b0;
            rd_r <= 1'b0;
            wel_r <= 1'b0;
            pend_r <= 1'b0;
            srwd_r <= 1'b0;
            bp_r <= EESFE_BP_NONE;
            miso_r <= 1'b0;
            bit_r <= EESFE_BIT_FIRST;
            ocnt_r <= EESFE_BIT_FIRST;
            sh_r <= 8'h00;
            osh_r <= 8'h00;
            addr_r <= '0;
            st_r <= ST_OPCODE;
        end
        else
        begin
            sck_d_r <= ps.sck;
            cs_d_r <= ps.cs_n;
            armed_r <= armed_nxt;
            hold_r <= hold_nxt;
            talk_r <= talk_nxt;
            rd_r <= rd_nxt;
            wel_r <= wel_nxt;
            pend_r <= pend_nxt;
            srwd_r <= srwd_nxt;
            bp_r <= bp_nxt;
            miso_r <= miso_nxt;
            bit_r <= bit_nxt;
            ocnt_r <= ocnt_nxt;
            sh_r <= sh_nxt;
            osh_r <= osh_nxt;
            addr_r <= addr_nxt;
            st_r <= st_nxt;
        end
    end

    // array is not reset: contents survive like nonvolatile cells
    always_ff @(posedge i_clk)
    begin
        if (mem_we)
            mem_r[mem_wa] <= mem_wd;
    end

    assign o_link.miso = miso_r;
    assign o_link.miso_oe = sel & ~hold_r & talk_r;
    assign o_state.active = sel;
    assign o_state.standby = ~sel;
    assign o_state.held = hold_r;
    assign o_state.armed = armed_r;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_off_deselected;
        ps.cs_n |-> !o_link.miso_oe;
    endproperty
    a_off_deselected: assert property (p_off_deselected)
        else $error("output driven while deselected");

    property p_off_held;
        hold_r && sel |-> !o_link.miso_oe
            ##1 ($stable(bit_r) && $stable(o_link.miso));
    endproperty
    a_off_held: assert property (p_off_held)
        else $error("hold did not silence the link");

    property p_unarmed;
        !armed_r |-> st_r == ST_OPCODE && !o_state.active;
    endproperty
    a_unarmed: assert property (p_unarmed)
        else $error("activity before first select fall");

    property p_miso_on_fall;
        $changed(o_link.miso) |-> $past(fall);
    endproperty
    a_miso_on_fall: assert property (p_miso_on_fall)
        else $error("output bit changed without a falling edge");

    property p_capture_on_rise;
        sel && $past(sel) && $changed(bit_r) |-> $past(rise);
    endproperty
    a_capture_on_rise: assert property (p_capture_on_rise)
        else $error("input bit taken without a rising edge");

    property p_sr_msb;
        fall && st_r == ST_RDSR && ocnt_r == EESFE_BIT_FIRST
            |=> o_link.miso == $past(status[EESFE_SR_SRWD]);
    endproperty
    a_sr_msb: assert property (p_sr_msb)
        else $error("status byte not sent msb first");

    property p_oe_start;
        // leaving hold re-enables the output without a falling edge
        $rose(o_link.miso_oe) && !$past(hold_r) |-> $past(fall) && out_phase;
    endproperty
    a_oe_start: assert property (p_oe_start)
        else $error("output enabled off a falling edge");

    property p_bad_opcode;
        rise && st_r == ST_OPCODE && bit_r == EESFE_BIT_LAST
            && byte_in == 8'hFF |=> st_r == ST_IGNORE;
    endproperty
    a_bad_opcode: assert property (p_bad_opcode)
        else $error("unknown opcode not ignored");

    property p_frozen;
        frozen |=> bp_r == $past(bp_r);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("block protect changed while frozen");

    property p_hold_abort;
        hold_r && ps.cs_n |=> !hold_r && st_r == ST_OPCODE
            && bit_r == EESFE_BIT_FIRST;
    endproperty
    a_hold_abort: assert property (p_hold_abort)
        else $error("deselect in hold did not reset state");

    c_read: cover property (fall && st_r == ST_RD_DATA);
    c_rdsr: cover property (fall && st_r == ST_RDSR);
    c_hold: cover property ($rose(hold_r));
    c_write: cover property (mem_we);
endmodule : eesfe_front
`default_nettype wire

// [design/eesfe_sync2.sv]
/*
 * eesfe_sync2: two-flop synchroniser for one asynchronous pin.
 * Assumes i_rst is synchronous to i_clk; INIT is the level o_q shows through reset.
 */
`timescale 1ns/1ps
`default_nettype none
module eesfe_sync2 #(
    parameter logic INIT = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_d,
    output logic o_q
);
    logic meta_r;
    logic sync_r;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            meta_r <= INIT;
            sync_r <= INIT;
        end
        else
        begin
            meta_r <= i_d;
            sync_r <= meta_r;
        end
    end

    assign o_q = sync_r;
endmodule : eesfe_sync2
`default_nettype wire

// [testbench/eesfe_master.sv]
/*
 * eesfe_master: behavioural SPI bus master facing the EEPROM front end.
 * Assumes the bench calls its tasks; pins change on falling i_clk edges.
 */
`timescale 1ns/1ps
`default_nettype none
module eesfe_master (
    input wire logic i_clk,
    input wire logic i_miso,
    output var eesfe_pkg::eesfe_pins_t o_pins
);
    import eesfe_pkg::*;
    logic cpol = 1'h0;
    initial o_pins = EESFE_PIN_IDLE;

    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask : tick

    // one device per bus here, so only this front end is selected
    task automatic start(input logic mode);
        cpol = mode;
        o_pins.sck = mode;
        tick(4);
        o_pins.cs_n = 1'h0;
        tick(4);
    endtask : start

    // 800 ns serial period: four system clocks per level
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int b = 7; b >= 0; b--)
        begin
            o_pins.sck = 1'h0;
            o_pins.mosi = tx[b];
            tick(4);
            rx[b] = i_miso;
            o_pins.sck = 1'h1;
            tick(4);
        end
    endtask : xbyte

    task automatic stop();
        if (!cpol)
        begin
            o_pins.sck = 1'h0;
            tick(4);
        end
        o_pins.cs_n = 1'h1;
        // released data line must not keep its last bit
        o_pins.mosi = ~o_pins.mosi;
        tick(6);
    endtask : stop

    task automatic hold_on();
        o_pins.sck = 1'h0;
        tick(4);
        o_pins.hold_n = 1'h0;
        repeat (4)
        begin
            tick(4);
            o_pins.sck = ~o_pins.sck;
            o_pins.mosi = ~o_pins.mosi;
        end
        tick(4);
    endtask : hold_on

    task automatic hold_off(input logic drop);
        if (drop)
        begin
            o_pins.cs_n = 1'h1;
            tick(4);
        end
        o_pins.hold_n = 1'h1;  // sck is low here
        tick(6);
    endtask : hold_off

    // only called between frames, so never inside a write
    task automatic set_wp(input logic v);
        o_pins.wp_n = v;
        tick(4);
    endtask : set_wp
endmodule : eesfe_master
`default_nettype wire

// [testbench/spi_eeprom_serial_front_end_bench.sv]
/*
 * Bench of the EEPROM serial front end: random writes and reads in both
 * modes, hold, abort, bad opcode and protection. Assumes eesfe_master.
 */
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_serial_front_end_bench;
    import eesfe_pkg::*;
    logic i_clk = 1'h0;
    logic i_rst = 1'h1;
    eesfe_pins_t pins;
    eesfe_link_t link;
    eesfe_state_t state;
    wire miso_w;
    int bad_count = 0;
    int checked = 0;
    logic [31:0] seed = 32'hBDA99F9A;
    logic [7:0] mem [0:2047];
    logic [7:0] rx;
    logic [10:0] ad;
    logic md = 1'h0;
    logic wel = 1'h0;
    logic srwd = 1'h0;
    logic wp = 1'h1;
    logic [1:0] bp = 2'h0;

    assign miso_w = link.miso_oe ? link.miso : 1'bz;
    initial forever #50 i_clk = ~i_clk;

    eesfe_front #(.P_LARGE(1'h1)) i_eesfe_front (.i_clk(i_clk),
        .i_rst(i_rst), .i_pins(pins), .o_link(link), .o_state(state));
    eesfe_master i_eesfe_master (.i_clk(i_clk), .i_miso(miso_w),
        .o_pins(pins));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic prot(input logic [10:0] a);
        return bp == EESFE_BP_ALL || (bp == EESFE_BP_HALF && a[10])
            || (bp == EESFE_BP_QUARTER && a[10:9] == 2'h3);
    endfunction : prot

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    task automatic op1(input logic [7:0] op);
        i_eesfe_master.start(md);
        i_eesfe_master.xbyte(op, rx);
        i_eesfe_master.stop();
    endtask : op1

    task automatic rdsr(input logic [7:0] m);
        i_eesfe_master.start(md);
        check(state.active, 1'h1);
        i_eesfe_master.xbyte(EESFE_OP_RDSR, rx);
        i_eesfe_master.xbyte(8'h00, rx);
        check(rx & m, {srwd, 3'h0, bp, wel, 1'h0} & m);
        i_eesfe_master.stop();
        check(state.standby, 1'h1);
        check(link.miso_oe, 1'h0);
    endtask : rdsr

    task automatic wrsr(input logic [7:0] v);
        op1(EESFE_OP_WREN);
        i_eesfe_master.start(md);
        i_eesfe_master.xbyte(EESFE_OP_WRSR, rx);
        i_eesfe_master.xbyte(v, rx);
        i_eesfe_master.stop();
        if (!(srwd && !wp))
        begin
            {srwd, bp} = {v[7], v[3:2]};
            wel = 1'h0;
        end
    endtask : wrsr

    task automatic wr(input logic [10:0] a, input int n);
        logic [7:0] d;
        op1(EESFE_OP_WREN);
        i_eesfe_master.start(md);
        i_eesfe_master.xbyte(EESFE_OP_WRITE, rx);
        i_eesfe_master.xbyte({5'h00, a[10:8]}, rx);
        i_eesfe_master.xbyte(a[7:0], rx);
        repeat (n)
        begin
            seed = lfsr(seed);
            d = seed[7:0];
            i_eesfe_master.xbyte(d, rx);
            if (!prot(a))
                mem[a] = d;
            a = a + 11'h001;
        end
        i_eesfe_master.stop();
        wel = 1'h0;
    endtask : wr

    task automatic rd(input logic [10:0] a, input int n, input logic h);
        i_eesfe_master.start(md);
        i_eesfe_master.xbyte(EESFE_OP_READ, rx);
        i_eesfe_master.xbyte({5'h00, a[10:8]}, rx);
        check(link.miso_oe, 1'h0);
        if (h)
        begin
            i_eesfe_master.hold_on();
            check(state.held, 1'h1);
            check(link.miso_oe, 1'h0);
            i_eesfe_master.hold_off(1'h0);
            check(state.held, 1'h0);
        end
        i_eesfe_master.xbyte(a[7:0], rx);
        repeat (n)
        begin
            i_eesfe_master.xbyte(8'h00, rx);
            check(rx, mem[a]);
            a = a + 11'h001;
        end
        i_eesfe_master.stop();
    endtask : rd

    initial
    begin
        // the eight cycles of start double as reset; select is low before
        // release, so no falling edge is seen and the opcode is ignored
        i_eesfe_master.start(md);
        i_rst = 1'h0;
        i_eesfe_master.xbyte(EESFE_OP_WREN, rx);
        check(state.armed, 1'h0);
        check(state.standby, 1'h1);
        check(link.miso_oe, 1'h0);
        i_eesfe_master.stop();
        rdsr(8'hFF);
        check(state.armed, 1'h1);
        $display("reset test done");
        for (int m = 0; m < 2; m++)
        begin
            md = m[0];
            op1(EESFE_OP_WREN);
            wel = 1'h1;
            rdsr(8'hFF);
            op1(EESFE_OP_WRDI);
            wel = 1'h0;
            rdsr(8'hFF);
            wr(11'h7FE, 3);
            rd(11'h7FE, 3, md);
            seed = lfsr(seed);
            ad = seed[10:0];
            wr(ad, 5);
            rd(ad, 5, ~md);
            $display("mode %0d test done", m);
        end
        md = 1'h0;
        i_eesfe_master.start(md);
        i_eesfe_master.xbyte(8'hFF, rx);
        i_eesfe_master.xbyte(8'h00, rx);
        check(link.miso_oe, 1'h0);
        i_eesfe_master.stop();
        i_eesfe_master.start(md);
        i_eesfe_master.xbyte(EESFE_OP_READ, rx);
        i_eesfe_master.hold_on();
        i_eesfe_master.hold_off(1'h1);
        check(state.held, 1'h0);
        rdsr(8'hFF);
        $display("opcode and abort test done");
        // known contents first, so dropped writes are told from kept ones
        wr(11'h123, 2);
        wr(11'h5FE, 4);
        wrsr(8'h8C);
        rdsr(8'hFF);
        wp = 1'h0;
        i_eesfe_master.set_wp(wp);
        wrsr(8'h00);
        rdsr(8'h8C);
        wr(11'h123, 2);
        rd(11'h123, 2, 1'h0);
        wp = 1'h1;
        i_eesfe_master.set_wp(wp);
        wrsr(8'h04);
        rdsr(8'hFF);
        wr(11'h5FE, 4);
        rd(11'h5FE, 4, 1'h0);
        $display("protect test done");
        end_sim();
    end

    initial
    begin
        repeat (60000) @(posedge i_clk);
        bad_count++;
        $display("Error at %0t: run did not finish", $time);
        end_sim();
    end
endmodule : spi_eeprom_serial_front_end_bench
`default_nettype wire
